//--- include/battery_protect_pkg.sv
package battery_protect_pkg;

    // ---------------------------------------------------------------
    // clocking and delay base
    // ---------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int TICK_US = 10;
    localparam int PRESCALE_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
    localparam int PRESCALE_W = 12;
    localparam int TICK_W = 20;

    // ---------------------------------------------------------------
    // delay times in microseconds
    // ---------------------------------------------------------------
    localparam int OVCH_DET_US = 1_000_000;
    localparam int OVCH_REL_US = 16_000;
    localparam int OVDS_DET_US = 128_000;
    localparam int OVDS_REL_US = 1_200;
    localparam int DOC_DET_US = 12_000;
    localparam int DOC_REL_US = 1_200;
    localparam int SHORT_DET_US = 300;
    localparam int COC_DET_US = 8_000;
    localparam int COC_REL_US = 1_200;

    // ---------------------------------------------------------------
    // delay counts in prescaler ticks and delay shorten divisor
    // ---------------------------------------------------------------
    localparam int OVCH_DET_TICKS = OVCH_DET_US / TICK_US;
    localparam int OVCH_REL_TICKS = OVCH_REL_US / TICK_US;
    localparam int OVDS_DET_TICKS = OVDS_DET_US / TICK_US;
    localparam int OVDS_REL_TICKS = OVDS_REL_US / TICK_US;
    localparam int DOC_DET_TICKS = DOC_DET_US / TICK_US;
    localparam int DOC_REL_TICKS = DOC_REL_US / TICK_US;
    localparam int SHORT_DET_TICKS = SHORT_DET_US / TICK_US;
    localparam int COC_DET_TICKS = COC_DET_US / TICK_US;
    localparam int COC_REL_TICKS = COC_REL_US / TICK_US;
    localparam int DS_DIVISOR = 16;

    // ---------------------------------------------------------------
    // comparator vector layout
    // ---------------------------------------------------------------
    localparam int SYNC_W = 11;
    localparam int IN_C1_OVCH = 0;
    localparam int IN_C2_OVCH = 1;
    localparam int IN_C1_OVDS = 2;
    localparam int IN_C2_OVDS = 3;
    localparam int IN_C1_ODREL = 4;
    localparam int IN_C2_ODREL = 5;
    localparam int IN_DOC = 6;
    localparam int IN_SHORT = 7;
    localparam int IN_COC = 8;
    localparam int IN_DS = 9;
    localparam int IN_CHARGER = 10;

    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic GATE_RST = 1'h1;
    localparam logic PULLDOWN_RST = 1'h0;
    localparam logic STANDBY_RST = 1'h0;

    typedef enum logic [1:0] {OPT_A, OPT_B, OPT_C, OPT_D} option_t;

    typedef enum logic [2:0] {
        ST_NORMAL, ST_OVERCHARGE, ST_OVERDISCH, ST_DCH_OVERCUR, ST_CHG_OVERCUR
    } prot_state_t;

    typedef enum logic [3:0] {
        EV_NONE, EV_OVCH_DET, EV_OVCH_REL, EV_OVDS_DET, EV_OVDS_REL, EV_DOC_DET,
        EV_DOC_REL, EV_SHORT_DET, EV_COC_DET, EV_COC_REL, EV_SPLIT
    } delay_event_t;

endpackage

//--- hdl/comparator_sync.sv
`timescale 1ns/1ps
module comparator_sync
    import battery_protect_pkg::*;
#(
    parameter int W = SYNC_W
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // raw comparator levels
    input wire logic [W-1:0] async_i,
    // synchronised levels
    output logic [W-1:0] sync_o
);

    // ---------------------------------------------------------------
    // two-stage synchroniser per bit
    // ---------------------------------------------------------------
    for (genvar i = 0; i < W; i++) begin : g_bit
        logic meta_q;
        logic stable_q;
        always_ff @(posedge clock_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                meta_q <= 1'h0;
                stable_q <= 1'h0;
            end else begin
                meta_q <= async_i[i];
                stable_q <= meta_q;
            end
        end
        assign sync_o[i] = stable_q;
    end

endmodule

//--- hdl/battery_protect_fsm.sv
`timescale 1ns/1ps
module battery_protect_fsm
    import battery_protect_pkg::*;
#(
    parameter option_t OPTION = OPT_A,
    parameter int PRESCALE = PRESCALE_CYCLES,
    parameter int OVCH_DET = OVCH_DET_TICKS,
    parameter int OVCH_REL = OVCH_REL_TICKS,
    parameter int OVDS_DET = OVDS_DET_TICKS,
    parameter int OVDS_REL = OVDS_REL_TICKS,
    parameter int DOC_DET = DOC_DET_TICKS,
    parameter int DOC_REL = DOC_REL_TICKS,
    parameter int SHORT_DET = SHORT_DET_TICKS,
    parameter int COC_DET = COC_DET_TICKS,
    parameter int COC_REL = COC_REL_TICKS,
    parameter int DS_DIV = DS_DIVISOR
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // cell voltage comparators
    input wire logic cell1_overcharge_det_i,
    input wire logic cell2_overcharge_det_i,
    input wire logic cell1_overdischarge_det_i,
    input wire logic cell2_overdischarge_det_i,
    input wire logic cell1_od_release_det_i,
    input wire logic cell2_od_release_det_i,
    // current sense, delay shorten and charger comparators
    input wire logic discharge_overcurrent_det_i,
    input wire logic short_circuit_det_i,
    input wire logic charge_overcurrent_det_i,
    input wire logic delay_shorten_function_i,
    input wire logic charger_det_i,
    // gate drive and housekeeping
    output logic charge_gate_o,
    output logic discharge_gate_o,
    output logic sense_pulldown_en_o,
    output logic standby_o
);

    // ---------------------------------------------------------------
    // input synchronisation
    // ---------------------------------------------------------------
    logic [SYNC_W-1:0] raw_in;
    logic [SYNC_W-1:0] sync_in;

    assign raw_in[IN_C1_OVCH] = cell1_overcharge_det_i;
    assign raw_in[IN_C2_OVCH] = cell2_overcharge_det_i;
    assign raw_in[IN_C1_OVDS] = cell1_overdischarge_det_i;
    assign raw_in[IN_C2_OVDS] = cell2_overdischarge_det_i;
    assign raw_in[IN_C1_ODREL] = cell1_od_release_det_i;
    assign raw_in[IN_C2_ODREL] = cell2_od_release_det_i;
    assign raw_in[IN_DOC] = discharge_overcurrent_det_i;
    assign raw_in[IN_SHORT] = short_circuit_det_i;
    assign raw_in[IN_COC] = charge_overcurrent_det_i;
    assign raw_in[IN_DS] = delay_shorten_function_i;
    assign raw_in[IN_CHARGER] = charger_det_i;

    comparator_sync #(.W(SYNC_W)) u_sync (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .async_i(raw_in),
        .sync_o(sync_in)
    );

    logic ovch_any;
    logic ovds_any;
    logic od_rel_both;
    logic load_s;
    logic short_s;
    logic coc_s;
    logic ds_s;
    logic charger_s;

    assign ovch_any = sync_in[IN_C1_OVCH] | sync_in[IN_C2_OVCH];
    assign ovds_any = sync_in[IN_C1_OVDS] | sync_in[IN_C2_OVDS];
    assign od_rel_both = sync_in[IN_C1_ODREL] & sync_in[IN_C2_ODREL];
    assign load_s = sync_in[IN_DOC];
    assign short_s = sync_in[IN_SHORT];
    assign coc_s = sync_in[IN_COC];
    assign ds_s = sync_in[IN_DS];
    assign charger_s = sync_in[IN_CHARGER];

    // ---------------------------------------------------------------
    // state and registered outputs
    // ---------------------------------------------------------------
    prot_state_t state_q;
    prot_state_t state_d;
    delay_event_t pend_q;
    delay_event_t pend_d;
    logic charge_gate_q;
    logic discharge_gate_q;
    logic pulldown_q;
    logic standby_q;
    logic charger_prev_q;
    logic [PRESCALE_W-1:0] presc_q;
    logic [TICK_W-1:0] elapsed_q;
    logic [TICK_W-1:0] limit_cur;
    logic shorten;
    logic fire;
    logic chg_rise;

    assign shorten = charge_gate_q & ds_s;
    assign chg_rise = charger_s & ~charger_prev_q;

    // ---------------------------------------------------------------
    // delay limits
    // ---------------------------------------------------------------
    function automatic logic [TICK_W-1:0] scaled(input int full, input logic short_en);
        int v;
        v = short_en ? full / DS_DIV : full;
        if (v < 1) begin
            v = 1;
        end
        return TICK_W'(v);
    endfunction

    always_comb begin
        unique case (pend_q)
            EV_OVCH_DET: limit_cur = scaled(OVCH_DET, shorten);
            EV_OVCH_REL: limit_cur = scaled(OVCH_REL, shorten);
            EV_OVDS_DET: limit_cur = scaled(OVDS_DET, shorten);
            EV_OVDS_REL: limit_cur = scaled(OVDS_REL, shorten);
            EV_DOC_DET: limit_cur = scaled(DOC_DET, 1'h0);
            EV_DOC_REL: limit_cur = scaled(DOC_REL, 1'h0);
            EV_SHORT_DET: limit_cur = scaled(SHORT_DET, 1'h0);
            EV_COC_DET: limit_cur = scaled(COC_DET, 1'h0);
            EV_COC_REL: limit_cur = scaled(COC_REL, 1'h0);
            // discharge gate turns back on in the same cycle as the charge gate drops
            EV_SPLIT: limit_cur = (OVDS_DET > OVCH_REL) ? scaled(OVDS_DET, 1'h0)
                                                        : scaled(OVCH_REL, 1'h0);
            default: limit_cur = '1;
        endcase
    end

    // ---------------------------------------------------------------
    // pending delay selection
    // ---------------------------------------------------------------
    always_comb begin
        pend_d = EV_NONE;
        unique case (state_q)
            ST_NORMAL: begin
                // current faults only with both gates on
                if (short_s) begin
                    pend_d = EV_SHORT_DET;
                end else if (load_s) begin
                    pend_d = EV_DOC_DET;
                end else if (coc_s) begin
                    pend_d = EV_COC_DET;
                end else if (ovch_any) begin
                    pend_d = EV_OVCH_DET;
                end else if (ovds_any) begin
                    pend_d = EV_OVDS_DET;
                end
            end
            ST_OVERCHARGE: begin
                // overdischarge, short and charge-current events ignored here
                if (!ovch_any && load_s && !charger_s) begin
                    pend_d = EV_OVCH_REL;
                end
            end
            ST_OVERDISCH: begin
                if (OPTION == OPT_C && charger_s && ovch_any) begin
                    pend_d = EV_SPLIT;
                end else if (charger_s && !ovds_any) begin
                    pend_d = EV_OVDS_REL;
                end else if (OPTION == OPT_A && od_rel_both) begin
                    pend_d = EV_OVDS_REL;
                end
            end
            ST_DCH_OVERCUR: begin
                if (!load_s) begin
                    pend_d = EV_DOC_REL;
                end
            end
            ST_CHG_OVERCUR: begin
                if (!charger_s && load_s) begin
                    pend_d = EV_COC_REL;
                end
            end
        endcase
    end

    assign fire = (pend_q == pend_d) && (pend_q != EV_NONE) && (elapsed_q >= limit_cur);

    // ---------------------------------------------------------------
    // shared prescaled delay counter
    // ---------------------------------------------------------------
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pend_q <= EV_NONE;
            presc_q <= '0;
            elapsed_q <= '0;
        end else begin
            pend_q <= pend_d;
            // a change of condition restarts the count
            if (pend_d != pend_q) begin
                presc_q <= '0;
                elapsed_q <= '0;
            end else if (presc_q == PRESCALE_W'(PRESCALE - 1)) begin
                presc_q <= '0;
                if (elapsed_q != '1) begin
                    elapsed_q <= elapsed_q + 1'h1;
                end
            end else begin
                presc_q <= presc_q + 1'h1;
            end
        end
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        if (state_q == ST_OVERDISCH && chg_rise && !ovds_any) begin
            state_d = ST_NORMAL;
        end else if (fire) begin
            unique case (pend_q)
                EV_SHORT_DET, EV_DOC_DET: state_d = ST_DCH_OVERCUR;
                EV_COC_DET: state_d = ST_CHG_OVERCUR;
                EV_OVCH_DET: state_d = ST_OVERCHARGE;
                EV_OVDS_DET: state_d = ST_OVERDISCH;
                EV_SPLIT: state_d = ST_OVERCHARGE;
                default: state_d = ST_NORMAL;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= ST_NORMAL;
            charger_prev_q <= 1'h0;
        end else begin
            state_q <= state_d;
            charger_prev_q <= charger_s;
        end
    end

    // ---------------------------------------------------------------
    // gate drive, pull-down and standby
    // ---------------------------------------------------------------
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            charge_gate_q <= GATE_RST;
            discharge_gate_q <= GATE_RST;
            pulldown_q <= PULLDOWN_RST;
            standby_q <= STANDBY_RST;
        end else begin
            // each transition moves one gate only, except EV_SPLIT, which moves both
            charge_gate_q <= !(state_d inside {ST_OVERCHARGE, ST_CHG_OVERCUR});
            discharge_gate_q <= !(state_d inside {ST_OVERDISCH, ST_DCH_OVERCUR});
            pulldown_q <= (state_d == ST_DCH_OVERCUR);
            standby_q <= (state_d == ST_OVERDISCH);
        end
    end

    assign charge_gate_o = charge_gate_q;
    assign discharge_gate_o = discharge_gate_q;
    assign sense_pulldown_en_o = pulldown_q;
    assign standby_o = standby_q;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_plug_healthy;
        state_q == ST_OVERDISCH && chg_rise && !ovds_any;
    endsequence

    sequence s_enter_ovch;
        state_q == ST_NORMAL ##1 state_q == ST_OVERCHARGE;
    endsequence

    sequence s_enter_doc;
        state_q == ST_NORMAL ##1 state_q == ST_DCH_OVERCUR;
    endsequence

    AST_NEVER_BOTH_FALL: assert property (
        !($fell(charge_gate_q) && $fell(discharge_gate_q))
    ) else $error("both gates switched off together");

    AST_OVCH_FULL_DELAY: assert property (
        s_enter_ovch |-> $past(ovch_any, 1) && $past(elapsed_q, 1) >= $past(limit_cur, 1)
            && $past(pend_q, 1) == EV_OVCH_DET
    ) else $error("overcharge entered before its delay");

    AST_OVCH_GATE_LOW: assert property (
        s_enter_ovch |-> !charge_gate_q && discharge_gate_q
    ) else $error("overcharge state without charge gate low");

    AST_OVCH_LATCHED: assert property (
        state_q == ST_OVERCHARGE && charger_s |=> state_q == ST_OVERCHARGE
    ) else $error("overcharge released with charger present");

    AST_DOC_GATES_ON: assert property (
        s_enter_doc |-> $past(charge_gate_q, 1) && $past(discharge_gate_q, 1)
    ) else $error("current fault taken with a gate off");

    AST_DOC_PULLDOWN: assert property (
        s_enter_doc |=> sense_pulldown_en_o && !discharge_gate_o
    ) else $error("pull-down not enabled in current fault");

    AST_PULLDOWN_ONLY_FAULT: assert property (
        sense_pulldown_en_o |-> state_q == ST_DCH_OVERCUR
    ) else $error("pull-down enabled outside current fault");

    AST_STANDBY_WITH_OD: assert property (
        $rose(standby_o) |-> !discharge_gate_o && state_q == ST_OVERDISCH
    ) else $error("standby without overdischarge");

    AST_IMMEDIATE_RELEASE: assert property (
        s_plug_healthy |=> ##1 discharge_gate_o && !standby_o
    ) else $error("healthy charger did not release at once");

    AST_OD_NEEDS_CHARGER: assert property (
        state_q == ST_OVERDISCH && !charger_s && !(OPTION == OPT_A && od_rel_both)
            |=> state_q != ST_NORMAL
    ) else $error("overdischarge released without charger");

    AST_SHORTEN_CGATE: assert property (
        s_enter_ovch |-> $past(shorten, 1) || $past(elapsed_q, 1) >= TICK_W'(OVCH_DET)
    ) else $error("overcharge delay cut short without shorten request");

    AST_COC_CAUSE: assert property (
        state_q == ST_NORMAL ##1 state_q == ST_CHG_OVERCUR |-> $past(coc_s, 2)
    ) else $error("charge overcurrent without comparator");

endmodule

//--- test/pack_model.sv
`timescale 1ns/1ps
module pack_model
    import battery_protect_pkg::*;
(
    // scenario controls
    input wire logic [1:0] cell_high_i,
    input wire logic [1:0] cell_low_i,
    input wire logic [1:0] cell_rec_i,
    input wire logic load_i,
    input wire logic heavy_i,
    input wire logic short_i,
    input wire logic charger_i,
    input wire logic bad_charger_i,
    input wire logic ds_i,
    // device outputs
    input wire logic pulldown_en_i,
    input wire logic charge_gate_i,
    input wire logic discharge_gate_i,
    // comparator levels
    output logic [SYNC_W-1:0] comp_o
);
    logic sense_high;

    // a load lifts the sense pin only through an open gate
    // an open discharge gate leaves the pin high unless pulled down
    assign sense_high = heavy_i | short_i | (load_i & ~charge_gate_i)
        | (~discharge_gate_i & (load_i | ~pulldown_en_i));
    assign comp_o[IN_C1_OVCH] = cell_high_i[0];
    assign comp_o[IN_C2_OVCH] = cell_high_i[1];
    assign comp_o[IN_C1_OVDS] = cell_low_i[0];
    assign comp_o[IN_C2_OVDS] = cell_low_i[1];
    assign comp_o[IN_C1_ODREL] = cell_rec_i[0];
    assign comp_o[IN_C2_ODREL] = cell_rec_i[1];
    assign comp_o[IN_DOC] = sense_high;
    assign comp_o[IN_SHORT] = short_i;
    assign comp_o[IN_COC] = bad_charger_i & charger_i;
    assign comp_o[IN_DS] = ds_i;
    assign comp_o[IN_CHARGER] = charger_i;
endmodule

//--- test/two_cell_battery_protection_fsm_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
    $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module two_cell_battery_protection_fsm_test;
    import battery_protect_pkg::*;
    localparam int P = 4;
    localparam int OCD = 20, OCR = 8, ODD = 16, ODR = 4, DCD = 6;
    localparam int DCR = 4, SCD = 3, CCD = 5, CCR = 4, DSD = 4;
    logic clk = 1'h0;
    logic reset_n = 1'h0;
    logic [1:0] cell_high = 2'h0, cell_low = 2'h0, cell_rec = 2'h0;
    logic load = 1'h0, heavy = 1'h0, short_c = 1'h0, charger = 1'h0;
    logic bad_chg = 1'h0, ds = 1'h0;
    logic [SYNC_W-1:0] comp;
    logic cg, dg, pd, sb, cg_q, dg_q;
    logic cg_c, dg_c, pd_c, sb_c;
    int mismatches = 0, checked = 0;

    always #10 clk = ~clk;

    battery_protect_fsm #(.OPTION(OPT_A), .PRESCALE(P), .OVCH_DET(OCD), .OVCH_REL(OCR),
        .OVDS_DET(ODD), .OVDS_REL(ODR), .DOC_DET(DCD), .DOC_REL(DCR), .SHORT_DET(SCD),
        .COC_DET(CCD), .COC_REL(CCR), .DS_DIV(DSD)) battery_protect_fsm_inst (
        .clock_i(clk), .reset_n_i(reset_n),
        .cell1_overcharge_det_i(comp[IN_C1_OVCH]), .cell2_overcharge_det_i(comp[IN_C2_OVCH]),
        .cell1_overdischarge_det_i(comp[IN_C1_OVDS]),
        .cell2_overdischarge_det_i(comp[IN_C2_OVDS]),
        .cell1_od_release_det_i(comp[IN_C1_ODREL]), .cell2_od_release_det_i(comp[IN_C2_ODREL]),
        .discharge_overcurrent_det_i(comp[IN_DOC]), .short_circuit_det_i(comp[IN_SHORT]),
        .charge_overcurrent_det_i(comp[IN_COC]), .delay_shorten_function_i(comp[IN_DS]),
        .charger_det_i(comp[IN_CHARGER]), .charge_gate_o(cg), .discharge_gate_o(dg),
        .sense_pulldown_en_o(pd), .standby_o(sb));

    battery_protect_fsm #(.OPTION(OPT_C), .PRESCALE(P), .OVCH_DET(OCD), .OVCH_REL(OCR),
        .OVDS_DET(ODD), .OVDS_REL(ODR), .DOC_DET(DCD), .DOC_REL(DCR), .SHORT_DET(SCD),
        .COC_DET(CCD), .COC_REL(CCR), .DS_DIV(DSD)) battery_protect_fsm_c_inst (
        .clock_i(clk), .reset_n_i(reset_n),
        .cell1_overcharge_det_i(comp[IN_C1_OVCH]), .cell2_overcharge_det_i(comp[IN_C2_OVCH]),
        .cell1_overdischarge_det_i(comp[IN_C1_OVDS]),
        .cell2_overdischarge_det_i(comp[IN_C2_OVDS]),
        .cell1_od_release_det_i(comp[IN_C1_ODREL]), .cell2_od_release_det_i(comp[IN_C2_ODREL]),
        .discharge_overcurrent_det_i(comp[IN_DOC]), .short_circuit_det_i(comp[IN_SHORT]),
        .charge_overcurrent_det_i(comp[IN_COC]), .delay_shorten_function_i(comp[IN_DS]),
        .charger_det_i(comp[IN_CHARGER]), .charge_gate_o(cg_c), .discharge_gate_o(dg_c),
        .sense_pulldown_en_o(pd_c), .standby_o(sb_c));

    pack_model pack_model_inst (.cell_high_i(cell_high), .cell_low_i(cell_low),
        .cell_rec_i(cell_rec), .load_i(load), .heavy_i(heavy), .short_i(short_c),
        .charger_i(charger), .bad_charger_i(bad_chg), .ds_i(ds), .pulldown_en_i(pd),
        .charge_gate_i(cg), .discharge_gate_i(dg), .comp_o(comp));

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    always @(negedge clk) begin
        if (reset_n && cg_q && dg_q && !cg && !dg) `CHK(1'h0, 1'h1)
        cg_q = cg;
        dg_q = dg;
    end

    function automatic logic out_of(input int sel);
        return sel == 0 ? cg : sel == 1 ? dg : sel == 2 ? pd : sel == 3 ? sb : sel == 4 ? cg_c : dg_c;
    endfunction

    task automatic step(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
        end
    endtask

    // output must change after n cycles plus pipeline
    task automatic expect_at(input int sel, input logic v, input int n);
        int k;
        k = 0;
        while (out_of(sel) !== v && k < n + 8) begin
            step(1);
            k++;
        end
        if (out_of(sel) !== v) begin
            mismatches++;
            $display("[ERR] t=%0t got %h exp %h", $time, out_of(sel), v);
            final_report();
        end
        `CHK(k >= n + 2 && k <= n + 5, 1'h1)
    endtask

    task automatic hold_off(input int sel, input logic v, input int n);
        repeat (n) begin
            step(1);
            if (out_of(sel) !== v) break;
        end
        `CHK(out_of(sel), v)
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        step(16);
        `CHK({cg, dg, pd, sb}, 4'h c)
        reset_n = 1'h1;
        step(2);
        `CHK({cg, dg, pd, sb}, 4'h c)
        $display("test reset done");
    endtask

    task automatic t_overcharge();
        charger = 1'h1;
        cell_high = 2'h1;
        step(OCD * P - 6);
        cell_high = 2'h0;
        hold_off(0, 1'h1, OCD * P + 8);
        cell_high = 2'h2;
        expect_at(0, 1'h0, OCD * P);
        `CHK(dg, 1'h1)
        short_c = 1'h1;
        hold_off(1, 1'h1, SCD * P + 8);
        short_c = 1'h0;
        cell_high = 2'h0;
        load = 1'h1;
        hold_off(0, 1'h0, OCR * P + 8);
        charger = 1'h0;
        cell_high = 2'h1;
        load = 1'h1;
        hold_off(0, 1'h0, OCR * P + 8);
        cell_high = 2'h0;
        step(OCR * P - 6);
        load = 1'h0;
        hold_off(0, 1'h0, OCR * P + 8);
        load = 1'h1;
        expect_at(0, 1'h1, OCR * P);
        load = 1'h0;
        step(8);
        $display("test overcharge done");
    endtask

    task automatic t_overdisch();
        cell_low = 2'h1;
        step(ODD * P - 6);
        cell_low = 2'h0;
        hold_off(1, 1'h1, ODD * P + 8);
        cell_low = 2'h2;
        expect_at(1, 1'h0, ODD * P);
        `CHK({cg, sb}, 2'h3)
        charger = 1'h1;
        hold_off(1, 1'h0, 6);
        cell_low = 2'h0;
        expect_at(1, 1'h1, ODR * P);
        `CHK(sb, 1'h0)
        charger = 1'h0;
        cell_low = 2'h1;
        expect_at(1, 1'h0, ODD * P);
        cell_low = 2'h0;
        hold_off(1, 1'h0, 8);
        charger = 1'h1;
        expect_at(1, 1'h1, 0);
        charger = 1'h0;
        cell_low = 2'h2;
        expect_at(1, 1'h0, ODD * P);
        cell_low = 2'h0;
        cell_rec = 2'h1;
        hold_off(1, 1'h0, ODR * P + 8);
        cell_rec = 2'h3;
        expect_at(1, 1'h1, ODR * P);
        cell_rec = 2'h0;
        step(8);
        $display("test overdischarge done");
    endtask

    task automatic t_doc();
        `CHK(pd, 1'h0)
        heavy = 1'h1;
        step(DCD * P - 6);
        heavy = 1'h0;
        hold_off(1, 1'h1, DCD * P + 8);
        heavy = 1'h1;
        cell_low = 2'h1;
        expect_at(1, 1'h0, DCD * P);
        `CHK({pd, sb, cg}, 3'h5)
        hold_off(2, 1'h1, ODD * P + 8);
        `CHK(sb, 1'h0)
        cell_low = 2'h0;
        heavy = 1'h0;
        expect_at(1, 1'h1, DCR * P);
        `CHK(pd, 1'h0)
        short_c = 1'h1;
        expect_at(1, 1'h0, SCD * P);
        `CHK(pd, 1'h1)
        short_c = 1'h0;
        expect_at(1, 1'h1, DCR * P);
        step(8);
        $display("test discharge current done");
    endtask

    task automatic t_coc();
        charger = 1'h1;
        bad_chg = 1'h1;
        step(CCD * P - 6);
        bad_chg = 1'h0;
        hold_off(0, 1'h1, CCD * P + 8);
        bad_chg = 1'h1;
        expect_at(0, 1'h0, CCD * P);
        `CHK(dg, 1'h1)
        bad_chg = 1'h0;
        load = 1'h1;
        hold_off(0, 1'h0, CCR * P + 8);
        charger = 1'h0;
        expect_at(0, 1'h1, CCR * P);
        load = 1'h0;
        step(8);
        $display("test charge current done");
    endtask

    task automatic t_ds();
        ds = 1'h1;
        charger = 1'h1;
        cell_high = 2'h1;
        expect_at(0, 1'h0, OCD / DSD * P);
        ds = 1'h0;
        cell_high = 2'h0;
        charger = 1'h0;
        load = 1'h1;
        expect_at(0, 1'h1, OCR * P);
        load = 1'h0;
        step(4);
        ds = 1'h1;
        cell_low = 2'h2;
        expect_at(1, 1'h0, ODD / DSD * P);
        ds = 1'h0;
        cell_low = 2'h0;
        step(8);
        charger = 1'h1;
        expect_at(1, 1'h1, 0);
        charger = 1'h0;
        step(8);
        $display("test delay shorten done");
    endtask

    task automatic t_split();
        cell_low = 2'h1;
        expect_at(5, 1'h0, ODD * P);
        charger = 1'h1;
        cell_high = 2'h2;
        expect_at(5, 1'h1, ODD * P);
        `CHK({cg_c, sb_c, dg, sb}, 4'h1)
        charger = 1'h0;
        cell_high = 2'h0;
        cell_low = 2'h0;
        reset_n = 1'h0;
        step(2);
        `CHK({cg, dg, pd, sb, cg_c, dg_c, pd_c, sb_c}, 8'hcc)
        reset_n = 1'h1;
        step(2);
        `CHK({cg, dg, pd, sb, cg_c, dg_c, pd_c, sb_c}, 8'hcc)
        $display("test split and reset done");
    endtask

    initial begin
        t_reset();
        t_overcharge();
        t_overdisch();
        t_doc();
        t_coc();
        t_ds();
        t_split();
        final_report();
    end
endmodule
